// ### bench/fcbr_report_test.sv
// self-checking bench for the flow control buffer report framer
`include "fcbr_params.svh"
module fcbr_report_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [3:0]       sel = 4'h0;
  logic [31:0]      wdat = 32'h0, wb_dat_o, word_o, rd;
  logic             wb_ack_o, busy_o, word_valid_o, word_last_o, word_ready, loc_gen_o;
  logic [15:0]      occ = 16'h8000;
  logic             ovf = 1'b0, unf = 1'b0, issue = 1'b0;
  logic [2:0]       word_idx_o;
  logic [1:0]       tag_loc_o;
  logic [7:0][31:0] pkt;
  logic [7:0]       npkt;
  logic [31:0]      id = 32'h0;
  int               err_count = 0, compares = 0;
  localparam logic [31:0] TAG = 32'h5a3c_0f1e;
  localparam logic [63:0] ADJ = 64'hffff_ffff_fff0_bdc0; // negative: receive path
  localparam logic [63:0] SIZE = 64'h0000_0001_0000_0400;

  always #5 clk_i = ~clk_i;

  fcbr_report i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .occupancy_i(occ), .overflow_i(ovf), .underflow_i(unf),
    .issue_i(issue), .busy_o(busy_o), .word_o(word_o), .word_idx_o(word_idx_o),
    .word_valid_o(word_valid_o), .word_last_o(word_last_o), .word_ready_i(word_ready),
    .tag_loc_o(tag_loc_o), .loc_gen_o(loc_gen_o));

  fcbr_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .word_i(word_o),
    .idx_i(word_idx_o), .valid_i(word_valid_o), .last_i(word_last_o),
    .ready_o(word_ready), .pkt_o(pkt), .npkt_o(npkt));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; the answer is taken at the edge where ack is seen
  task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, wb_ack_o, 1'b1);
    end
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb_io

  // issue a packet, poke issue again while busy, then judge the words
  task automatic send(input logic s, input logic [31:0] st);
    logic [7:0] n0;
    int         n;
    slow <= s;
    n0 = npkt;
    @(posedge clk_i); issue <= 1'b1;
    @(posedge clk_i); issue <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({31'h0, busy_o}, 32'h1);
    issue <= 1'b1;
    @(posedge clk_i); issue <= 1'b0;
    n = 0;
    while (npkt === n0 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    repeat (3) @(posedge clk_i);
    chk({24'h0, npkt}, {24'h0, n0 + 8'h01});
    chk({31'h0, busy_o}, 32'h0);
    chk(pkt[0], TAG);
    chk(pkt[1], id);
    chk(pkt[2], `FCBR_CIF1_WORD);
    chk(pkt[3], ADJ[63:32]);
    chk(pkt[4], ADJ[31:0]);
    chk(pkt[5], SIZE[63:32]);
    chk(pkt[6], SIZE[31:0]);
    chk(pkt[7], st);
    id++;
  endtask : send

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    wb_io(1'b0, `FCBR_ADR_CTRL, 32'h0);   chk(rd, `FCBR_CTRL_RESET);
    wb_io(1'b0, `FCBR_ADR_THRESH, 32'h0); chk(rd, `FCBR_THRESH_RESET);
    wb_io(1'b0, `FCBR_ADR_MSGID, 32'h0);  chk(rd, 32'h0);
    // zero adjustment on the receive path counts as a sign mismatch
    wb_io(1'b0, `FCBR_ADR_STATUS, 32'h0); chk(rd, 32'h0000_0100);
    wb_io(1'b0, 8'h28, 32'h0);            chk(rd, 32'h0);
    chk({30'h0, tag_loc_o}, 32'h0);
    chk({31'h0, loc_gen_o}, 32'h1);
  endtask : t_reset

  // every location category on both paths, with the adjustment sign check
  task automatic t_config_loc;
    logic [2:0] c;
    wb_io(1'b1, `FCBR_ADR_TAG, TAG);
    wb_io(1'b1, `FCBR_ADR_ADJ_LO, ADJ[31:0]);
    wb_io(1'b1, `FCBR_ADR_ADJ_HI, ADJ[63:32]);
    wb_io(1'b1, `FCBR_ADR_SIZE_LO, SIZE[31:0]);
    wb_io(1'b1, `FCBR_ADR_SIZE_HI, SIZE[63:32]);
    for (int i = 7; i >= 0; i--)
    begin
      c = 3'(i);
      wb_io(1'b1, `FCBR_ADR_CTRL, {29'h0, c});
      repeat (2) @(posedge clk_i);
      chk({30'h0, tag_loc_o}, {30'h0, c[2:1]});
      chk({31'h0, loc_gen_o}, {31'h0, c[2:1] != 2'd1 && !(c[2:1] == 2'd2 && c[0])});
      wb_io(1'b0, `FCBR_ADR_STATUS, 32'h0);
      chk({31'h0, rd[`FCBR_STAT_MISM]}, {31'h0, c[0]});
    end
  endtask : t_config_loc

  // the level has been steady since reset, so both packets report it
  task automatic t_packet;
    send(1'b0, 32'h0000_8000);
    send(1'b1, 32'h0000_8000);
    wb_io(1'b0, `FCBR_ADR_MSGID, 32'h0);
    chk(rd, id);
  endtask : t_packet

  // empty, full, both thresholds at their edges and nearly-full just past its edge
  task automatic t_levels;
    logic [15:0] v [5];
    logic [31:0] e [5];
    logic [31:0] f [5];
    v = '{16'hffff, 16'h0000, 16'h2000, 16'he000, 16'he010};
    e = '{32'h0000_fff4, 32'h0000_0002, 32'h0000_2000, 32'h0000_e000, 32'h0000_e014};
    // the step is seen for one averaging update; flags of both levels are reported
    f = '{32'h0000_87f4, 32'h0000_eff6, 32'h0000_0202, 32'h0000_2c00, 32'h0000_e004};
    for (int i = 0; i < 5; i++)
    begin
      occ <= v[i];
      send(1'b0, f[i]);
      send(i[0], e[i]);
    end
  endtask : t_levels

  // one-cycle events set the sticky bits, the next interval starts clean
  task automatic t_flags;
    occ <= 16'h8000;
    send(1'b0, 32'h0000_da04);
    ovf <= 1'b1;
    @(posedge clk_i); ovf <= 1'b0; unf <= 1'b1;
    @(posedge clk_i); unf <= 1'b0; occ <= 16'hf000;
    @(posedge clk_i); occ <= 16'h1000;
    @(posedge clk_i); occ <= 16'h8000;
    // long enough for the truncating average to settle just below the level
    repeat (60) @(posedge clk_i);
    wb_io(1'b0, `FCBR_ADR_STATUS, 32'h0);
    chk({28'h0, rd[3:0]}, 32'hf);
    send(1'b0, 32'h0000_7fff);
    chk({28'h0, pkt[7][3:0]}, 32'hf);
    send(1'b1, 32'h0000_8000);
    wb_io(1'b0, `FCBR_ADR_LAST, 32'h0);
    chk(rd, 32'h0000_8000);
  endtask : t_flags

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_config_loc;
    t_packet;
    t_levels;
    t_flags;
    print_verdict;
  end

  // the whole run takes several hundred cycles
  initial
  begin
    #200000;
    err_count++;
    print_verdict;
  end
endmodule : fcbr_report_test

// ### bench/fcbr_sink.sv
// stream sink model that takes the report words, prompt or stalling
module fcbr_sink (
  input  wire logic              clk_i,   // 100 MHz clock
  input  wire logic              rst_i,   // synchronous reset, active high
  input  wire logic              slow_i,  // stall every other cycle
  input  wire logic [31:0]       word_i,  // packet word
  input  wire logic [2:0]        idx_i,   // word index
  input  wire logic              valid_i, // word valid
  input  wire logic              last_i,  // status word
  output logic                   ready_o, // word taken
  output logic      [7:0][31:0]  pkt_o,   // words of the last packet
  output logic      [7:0]        npkt_o   // packets completed
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////////////
  // ready only changes after an edge, never within a word's hold
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ready_o <= 1'b0;
      npkt_o  <= 8'h00;
    end
    else
    begin
      ready_o <= slow_i ? ~ready_o : 1'b1;
      if (valid_i && ready_o)
      begin
        pkt_o[idx_i] <= word_i;
        if (last_i)
          npkt_o <= npkt_o + 8'h01;
      end
    end
  end
endmodule : fcbr_sink

// ### rtl/fcbr_report.sv
// flow control buffer report framer with wishbone register slave
//
// The Wishbone slave port and the address map were left to the implementer.
`include "fcbr_params.svh"

module fcbr_report #(
  parameter int OCC_W     = 16,
  parameter int AVG_SHIFT = 4
) (
  input  wire logic             clk_i,        // 100 MHz clock
  input  wire logic             rst_i,        // synchronous reset, active high
  input  wire logic             wb_cyc_i,     // bus cycle
  input  wire logic             wb_stb_i,     // bus strobe
  input  wire logic             wb_we_i,      // write enable
  input  wire logic [7:0]       wb_adr_i,     // byte address
  input  wire logic [3:0]       wb_sel_i,     // byte lanes
  input  wire logic [31:0]      wb_dat_i,     // write data
  output logic      [31:0]      wb_dat_o,     // read data
  output logic                  wb_ack_o,     // acknowledge
  input  wire logic [OCC_W-1:0] occupancy_i,  // sink buffer occupancy, all ones is full
  input  wire logic             overflow_i,   // overflow event pulse
  input  wire logic             underflow_i,  // underflow event pulse
  input  wire logic             issue_i,      // request to issue a packet
  output logic                  busy_o,       // words of a packet still pending
  output logic      [31:0]      word_o,       // packet word
  output logic      [2:0]       word_idx_o,   // index of word_o in the packet
  output logic                  word_valid_o, // word_o is valid
  output logic                  word_last_o,  // word_o is the status word
  input  wire logic             word_ready_i, // sink takes word_o
  output logic      [1:0]       tag_loc_o,    // stream tag location category
  output logic                  loc_gen_o     // timestamp refers to sample generation
);

  localparam int AW = `FCBR_LEVEL_W + AVG_SHIFT;

  ////////////////////////////////////////////////////////////////////////////////
  // registers and wishbone slave

  logic [31:0] ctrl;
  logic [31:0] tag;
  logic [31:0] adj_lo;
  logic [31:0] adj_hi;
  logic [31:0] size_lo;
  logic [31:0] size_hi;
  logic [31:0] thresh;
  logic [31:0] next_ctrl;
  logic [31:0] next_tag;
  logic [31:0] next_adj_lo;
  logic [31:0] next_adj_hi;
  logic [31:0] next_size_lo;
  logic [31:0] next_size_hi;
  logic [31:0] next_thresh;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        wr;

  logic [3:0]    flags;
  logic [AW-1:0] avg;
  logic [31:0]   msgid;
  logic [31:0]   last_stat;
  logic          mismatch;
  fcbr_pkg::fcbr_state_type state;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = val[8*b +: 8];
    end
    return r;
  endfunction : merge

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  // a sign that contradicts the configured path is flagged, not altered
  assign mismatch = ctrl[`FCBR_CTRL_TX_BIT] ? adj_hi[31] : !adj_hi[31];

  always_comb
  begin
    next_ctrl    = ctrl;
    next_tag     = tag;
    next_adj_lo  = adj_lo;
    next_adj_hi  = adj_hi;
    next_size_lo = size_lo;
    next_size_hi = size_hi;
    next_thresh  = thresh;
    next_ack     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat     = 32'h0000_0000;
    if (wr && wb_adr_i == `FCBR_ADR_CTRL)
      next_ctrl = merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_0007;
    else if (wr && wb_adr_i == `FCBR_ADR_TAG)
      next_tag = merge(tag, wb_dat_i, wb_sel_i);
    else if (wr && wb_adr_i == `FCBR_ADR_ADJ_LO)
      next_adj_lo = merge(adj_lo, wb_dat_i, wb_sel_i);
    else if (wr && wb_adr_i == `FCBR_ADR_ADJ_HI)
      next_adj_hi = merge(adj_hi, wb_dat_i, wb_sel_i);
    else if (wr && wb_adr_i == `FCBR_ADR_SIZE_LO)
      next_size_lo = merge(size_lo, wb_dat_i, wb_sel_i);
    else if (wr && wb_adr_i == `FCBR_ADR_SIZE_HI)
      next_size_hi = merge(size_hi, wb_dat_i, wb_sel_i);
    else if (wr && wb_adr_i == `FCBR_ADR_THRESH)
      next_thresh = merge(thresh, wb_dat_i, wb_sel_i) & 32'h0fff_0fff;
    if (wb_adr_i == `FCBR_ADR_CTRL)
      next_dat = ctrl;
    else if (wb_adr_i == `FCBR_ADR_TAG)
      next_dat = tag;
    else if (wb_adr_i == `FCBR_ADR_ADJ_LO)
      next_dat = adj_lo;
    else if (wb_adr_i == `FCBR_ADR_ADJ_HI)
      next_dat = adj_hi;
    else if (wb_adr_i == `FCBR_ADR_SIZE_LO)
      next_dat = size_lo;
    else if (wb_adr_i == `FCBR_ADR_SIZE_HI)
      next_dat = size_hi;
    else if (wb_adr_i == `FCBR_ADR_THRESH)
      next_dat = thresh;
    else if (wb_adr_i == `FCBR_ADR_STATUS)
      next_dat = {23'h000000, mismatch, 3'h0, busy_o, flags};
    else if (wb_adr_i == `FCBR_ADR_MSGID)
      next_dat = msgid;
    else if (wb_adr_i == `FCBR_ADR_LAST)
      next_dat = last_stat;
    if (!next_ack)
      next_dat = 32'h0000_0000;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl     <= `FCBR_CTRL_RESET;
      tag      <= 32'h0000_0000;
      adj_lo   <= 32'h0000_0000;
      adj_hi   <= 32'h0000_0000;
      size_lo  <= 32'h0000_0000;
      size_hi  <= 32'h0000_0000;
      thresh   <= `FCBR_THRESH_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ctrl     <= next_ctrl;
      tag      <= next_tag;
      adj_lo   <= next_adj_lo;
      adj_hi   <= next_adj_hi;
      size_lo  <= next_size_lo;
      size_hi  <= next_size_hi;
      thresh   <= next_thresh;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interval monitor: sticky flags, average, message id

  logic [11:0]   level;
  logic          capture;
  logic          fresh;
  logic [3:0]    events;
  logic [3:0]    next_flags;
  logic [AW-1:0] next_avg;
  logic          next_fresh;
  logic [31:0]   next_msgid;
  logic [31:0]   next_last;
  logic [31:0]   stat_word;
  logic [AW+1:0] diff;

  // top bits of occupancy: all zeros reads 0x000, all ones reads 0xfff
  assign level   = occupancy_i[OCC_W-1 -: 12];
  assign capture = issue_i && state == fcbr_pkg::FCBR_IDLE;

  assign events[`FCBR_FLAG_OVF] = overflow_i;
  assign events[`FCBR_FLAG_NF]  = level > thresh[`FCBR_NF_LSB +: 12];
  assign events[`FCBR_FLAG_NE]  = level < thresh[`FCBR_NE_LSB +: 12];
  assign events[`FCBR_FLAG_UNF] = underflow_i;

  // reported word includes events seen in the capture cycle itself
  assign stat_word = {{`FCBR_RSVD_W{1'b0}}, avg[AW-1 -: 12], flags | events};

  assign diff = {2'b00, level, {AVG_SHIFT{1'b0}}} - {2'b00, avg};

  always_comb
  begin
    next_flags = flags | events;
    next_avg   = avg;
    next_fresh = 1'b0;
    next_msgid = msgid;
    next_last  = last_stat;
    // exponential average, reloaded by the first sample of each interval
    if (fresh)
      next_avg = {level, {AVG_SHIFT{1'b0}}};
    else
      next_avg = avg + AW'($signed(diff) >>> AVG_SHIFT);
    if (capture)
    begin
      // events of this cycle already went out, so the new interval starts clean
      next_flags = 4'h0;
      next_fresh = 1'b1;
      next_msgid = msgid + 32'h0000_0001;
      next_last  = stat_word;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags     <= 4'h0;
      avg       <= '0;
      // seed from the first sample, so the first interval is not a ramp up from zero
      fresh     <= 1'b1;
      msgid     <= 32'h0000_0000;
      last_stat <= 32'h0000_0000;
    end
    else
    begin
      flags     <= next_flags;
      avg       <= next_avg;
      fresh     <= next_fresh;
      msgid     <= next_msgid;
      last_stat <= next_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // word serializer

  logic [31:0] snap_tag;
  logic [31:0] snap_id;
  logic [31:0] snap_stat;
  logic [31:0] next_snap_tag;
  logic [31:0] next_snap_id;
  logic [31:0] next_snap_stat;
  logic [2:0]  next_idx;
  logic [31:0] next_word;
  logic [1:0]  next_loc;
  logic        next_gen;
  fcbr_pkg::fcbr_state_type next_state;

  // adjustment and size are read live, so software should not change them mid-packet
  function automatic logic [31:0] pick(input logic [2:0] i, input logic [31:0] t,
                                       input logic [31:0] id, input logic [31:0] st);
    case (i)
      3'h0:    pick = t;
      3'h1:    pick = id;
      3'h2:    pick = `FCBR_CIF1_WORD;
      3'h3:    pick = adj_hi;
      3'h4:    pick = adj_lo;
      3'h5:    pick = size_hi;
      3'h6:    pick = size_lo;
      default: pick = st;
    endcase
  endfunction : pick

  always_comb
  begin
    next_state     = state;
    next_idx       = word_idx_o;
    next_word      = word_o;
    next_snap_tag  = snap_tag;
    next_snap_id   = snap_id;
    next_snap_stat = snap_stat;
    case (state)
      fcbr_pkg::FCBR_IDLE:
      begin
        if (capture)
        begin
          next_state     = fcbr_pkg::FCBR_SEND;
          next_idx       = 3'h0;
          next_snap_tag  = tag;
          next_snap_id   = msgid;
          next_snap_stat = stat_word;
          next_word      = tag;
        end
      end
      default:
      begin
        if (word_ready_i)
        begin
          if (word_idx_o == `FCBR_LAST_IDX)
            next_state = fcbr_pkg::FCBR_IDLE;
          else
          begin
            next_idx  = word_idx_o + 3'h1;
            next_word = pick(word_idx_o + 3'h1, snap_tag, snap_id, snap_stat);
          end
        end
      end
    endcase
    // tag location follows the device category and path direction
    next_loc = ctrl[2:1];
    case (fcbr_pkg::fcbr_loc_type'(ctrl[2:1]))
      fcbr_pkg::FCBR_LOC_ADC:   next_gen = 1'b1;
      fcbr_pkg::FCBR_LOC_DAC:   next_gen = 1'b0;
      fcbr_pkg::FCBR_LOC_INTER: next_gen = !ctrl[`FCBR_CTRL_TX_BIT];
      default:                  next_gen = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state      <= fcbr_pkg::FCBR_IDLE;
      word_idx_o <= 3'h0;
      word_o     <= 32'h0000_0000;
      snap_tag   <= 32'h0000_0000;
      snap_id    <= 32'h0000_0000;
      snap_stat  <= 32'h0000_0000;
      tag_loc_o  <= 2'b00;
      loc_gen_o  <= 1'b1;
    end
    else
    begin
      state      <= next_state;
      word_idx_o <= next_idx;
      word_o     <= next_word;
      snap_tag   <= next_snap_tag;
      snap_id    <= next_snap_id;
      snap_stat  <= next_snap_stat;
      tag_loc_o  <= next_loc;
      loc_gen_o  <= next_gen;
    end
  end

  assign word_valid_o = state == fcbr_pkg::FCBR_SEND;
  assign word_last_o  = word_valid_o && word_idx_o == `FCBR_LAST_IDX;
  assign busy_o       = word_valid_o;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_reserved;
    @(posedge clk_i) disable iff (rst_i)
    word_last_o |-> word_o[31:16] == 16'h0000 && word_o[15:0] == snap_stat[15:0];
  endproperty
  a_reserved: assert property (p_reserved) else $error("status word wrong");

  property p_cif1;
    @(posedge clk_i) disable iff (rst_i)
    word_valid_o && word_idx_o == 3'h2 |-> word_o == 32'h0000_0002;
  endproperty
  a_cif1: assert property (p_cif1) else $error("indicator word wrong");

  property p_msgid;
    @(posedge clk_i) disable iff (rst_i)
    capture |=> msgid == $past(msgid) + 32'h0000_0001 && snap_id == $past(msgid);
  endproperty
  a_msgid: assert property (p_msgid) else $error("message id not sequential");

  property p_ovf;
    @(posedge clk_i) disable iff (rst_i)
    overflow_i && !capture |=> flags[3] throughout (!capture [*1]);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not sticky");

  property p_nf;
    @(posedge clk_i) disable iff (rst_i)
    $rose(level > thresh[27:16]) && !capture |=> flags[2];
  endproperty
  a_nf: assert property (p_nf) else $error("nearly full missed");

  property p_ne;
    @(posedge clk_i) disable iff (rst_i)
    level < thresh[11:0] && !capture |=> flags[1];
  endproperty
  a_ne: assert property (p_ne) else $error("nearly empty missed");

  property p_unf;
    @(posedge clk_i) disable iff (rst_i)
    capture && underflow_i |=> snap_stat[0] && !flags[0];
  endproperty
  a_unf: assert property (p_unf) else $error("underflow not reported");

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
    capture && !overflow_i && !underflow_i |=> flags[3] == 1'b0 && flags[0] == 1'b0;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");

  property p_size;
    @(posedge clk_i) disable iff (rst_i)
    word_valid_o && word_idx_o == 3'h5 && word_ready_i |=> word_o == size_lo;
  endproperty
  a_size: assert property (p_size) else $error("size words out of order");

  property p_reset;
    @(posedge clk_i)
    rst_i |=> flags == 4'h0 && avg == '0 && !word_valid_o;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  c_packet: cover property (@(posedge clk_i) disable iff (rst_i) word_last_o && word_ready_i);
  c_ovf:    cover property (@(posedge clk_i) disable iff (rst_i) capture && flags[3]);
  c_stall:  cover property (@(posedge clk_i) disable iff (rst_i)
                            word_valid_o && !word_ready_i [*3]);

endmodule : fcbr_report

// ### shared/fcbr_params.svh
// constants for the flow control buffer report framer
//
// Notes on behaviour
// - adjustment word pair is a signed 64-bit femtosecond delay, reference point to tag location.
// - adjustment should be positive on transmit path and negative on receive path.
// - buffer size field is sent as exactly three consecutive 32-bit words.
// - first two buffer words carry unsigned 64-bit sink buffer capacity in bytes.
// - upper 16 bits of the third buffer word are driven to zero.
// - 12-bit fill level sits in bits 15:4 of the third buffer word.
// - fill level maps empty to 0x000 and full to 0xfff proportionally.
// - fill level is the occupancy average over the interval since the last issue.
// - averaging method is the implementer's choice; here an exponential average.
// - bit 3 is set if any overflow happened in the current interval.
// - bit 2 is set if occupancy exceeded nearly-full threshold in the interval.
// - thresholds are configured outside the packet, never carried in packets.
// - bit 1 is set if occupancy fell below nearly-empty threshold in the interval.
// - bit 0 is set if any underflow happened in the current interval.
// - every packet carries a run-time selectable 32-bit stream tag.
// - data packets always carry integer and fractional seconds timestamps.
// - timestamp refers to the tag location; reference time is timestamp plus adjustment.
// - converter source: tag location is sample generation inside the ADC.
// - converter sink: tag location is sample consumption inside the DAC.
// - intermediate device: generation on receive, operation after buffering on transmit.
// - replication pair: tag location is sample generation inside the source converter.
// - each packet for a stream tag carries a sequentially increasing 32-bit message id.
// - second indicator word has only bit 1 set, announcing the buffer size field.
`ifndef FCBR_PARAMS_SVH
`define FCBR_PARAMS_SVH

`define FCBR_ADR_CTRL     8'h00
`define FCBR_ADR_TAG      8'h04
`define FCBR_ADR_ADJ_LO   8'h08
`define FCBR_ADR_ADJ_HI   8'h0c
`define FCBR_ADR_SIZE_LO  8'h10
`define FCBR_ADR_SIZE_HI  8'h14
`define FCBR_ADR_THRESH   8'h18
`define FCBR_ADR_STATUS   8'h1c
`define FCBR_ADR_MSGID    8'h20
`define FCBR_ADR_LAST     8'h24

`define FCBR_CTRL_TX_BIT  0
`define FCBR_CTRL_RESET   32'h0000_0000
`define FCBR_THRESH_RESET 32'h0e00_0200
`define FCBR_NE_LSB       0
`define FCBR_NF_LSB       16
`define FCBR_STAT_MISM    8
`define FCBR_STAT_BUSY    4

`define FCBR_CIF1_WORD    32'h0000_0002
`define FCBR_RSVD_W       16
`define FCBR_LEVEL_W      12
`define FCBR_FLAG_OVF     3
`define FCBR_FLAG_NF      2
`define FCBR_FLAG_NE      1
`define FCBR_FLAG_UNF     0
`define FCBR_LAST_IDX     3'h7

`endif

// ### shared/fcbr_pkg.sv
// types shared by the flow control buffer report framer
package fcbr_pkg;

  typedef enum logic [0:0] {
    FCBR_IDLE = 1'b0,
    FCBR_SEND = 1'b1
  } fcbr_state_type;

  // where the stream tag location sits, which fixes what the timestamp refers to
  typedef enum logic [1:0] {
    FCBR_LOC_ADC     = 2'b00,
    FCBR_LOC_DAC     = 2'b01,
    FCBR_LOC_INTER   = 2'b10,
    FCBR_LOC_BOOKEND = 2'b11
  } fcbr_loc_type;

endpackage : fcbr_pkg
